// File: hdl/reset_cause_status_register.sv
// Summary of operation
// - mismatch reset sets bit 9, else zero
// - bit 8 keeps regulator on in sleep
// - master clear pin reset sets bit 7
// - software reset sets bit 6
// - watchdog expiry sets bit 4
// - wake from sleep sets bit 3
// - wake from idle sets bit 2
// - brown-out reset sets bit 1
// - power-on reset sets bit 0
// - bits 31-10 and 5 read zero
// - hardware sets flags, software reads and writes
`timescale 1ns/10ps
module reset_cause_status_register (
  input  wire logic                         clk_sys_i,
  input  wire logic                         nrst_i,
  // ahb-lite slave
  input  wire logic                         hsel_i,
  input  wire logic [rcause_pkg::DATA_W-1:0] haddr_i,
  input  wire logic [1:0]                   htrans_i,
  input  wire logic                         hwrite_i,
  input  wire logic [2:0]                   hsize_i,
  input  wire logic                         hready_i,
  input  wire logic [rcause_pkg::DATA_W-1:0] hwdata_i,
  output      logic [rcause_pkg::DATA_W-1:0] hrdata_o,
  output      logic                         hreadyout_o,
  output      logic                         hresp_o,
  // reset causes and wake events, one-cycle pulses, and the active-low master clear pin level
  input  wire logic                         mismatch_evt_i,
  input  wire logic                         sw_reset_evt_i,
  input  wire logic                         wdt_timeout_evt_i,
  input  wire logic                         sleep_wake_evt_i,
  input  wire logic                         idle_wake_evt_i,
  input  wire logic                         brownout_evt_i,
  input  wire logic                         poweron_evt_i,
  input  wire logic                         master_clear_input_n_i,
  // power state
  input  wire logic                         in_sleep_i,
  output      logic                         regulator_on_o,
  output      logic                         regulator_standby_enable_o,
  output      logic                         irq_o
);
  import rcause_pkg::*;

  // address phase decode on the low word index, upper bits must be zero
  function automatic logic is_reg(input logic [DATA_W-1:0] addr, input logic [DATA_W-1:0] off);
    is_reg = (addr[DATA_W-1:2] == off[DATA_W-1:2]);
  endfunction : is_reg

  access_t             acc_r;
  logic [DATA_W-1:0]   addr_r;
  logic [DATA_W-1:0]   hrdata_r;
  logic [DATA_W-1:0]   rd_nxt;
  logic                addr_take;
  logic                wr_ctl;
  logic                wr_int_clear;
  logic                wr_int_enable;
  logic [DATA_W-1:0]   ctl_r;
  logic [DATA_W-1:0]   ctl_nxt;
  logic [DATA_W-1:0]   set_vec;
  logic                pin_s1_r;
  logic                pin_s2_r;
  logic                pin_prev_r;
  logic                pin_evt;
  logic                reg_on_r;

  irq_if irq_bus ();

  irq_bank u_irq_bank (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .bus       (irq_bus.bank)
  );

  // ---- bus slave ----
  assign addr_take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r <= ACC_NONE;
    end else if (hready_i) begin
      if (addr_take && hwrite_i) begin
        acc_r <= ACC_WRITE;
      end else if (addr_take) begin
        acc_r <= ACC_READ;
      end else begin
        acc_r <= ACC_NONE;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_r <= HRDATA_RESET;
    end else if (addr_take) begin
      addr_r <= haddr_i;
    end
  end

  // read data chosen in the address phase, presented in the data phase
  always_comb begin
    rd_nxt = HRDATA_RESET;
    if (is_reg(haddr_i, CTL_ADDR)) begin
      rd_nxt = ctl_r & CTL_IMPL_MASK;
    end else if (is_reg(haddr_i, INT_STATUS_ADDR)) begin
      rd_nxt = {{(DATA_W-FLAG_W){1'h0}}, irq_bus.status};
    end else if (is_reg(haddr_i, INT_ENABLE_ADDR)) begin
      rd_nxt = {{(DATA_W-FLAG_W){1'h0}}, irq_bus.enable};
    end else begin
      rd_nxt = HRDATA_RESET;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_r <= HRDATA_RESET;
    end else if (addr_take && !hwrite_i) begin
      hrdata_r <= rd_nxt;
    end
  end

  always_comb begin
    wr_ctl        = 1'h0;
    wr_int_clear  = 1'h0;
    wr_int_enable = 1'h0;
    if (acc_r == ACC_WRITE) begin
      if (is_reg(addr_r, CTL_ADDR)) begin
        wr_ctl = 1'h1;
      end else if (is_reg(addr_r, INT_CLEAR_ADDR)) begin
        wr_int_clear = 1'h1;
      end else if (is_reg(addr_r, INT_ENABLE_ADDR)) begin
        wr_int_enable = 1'h1;
      end
    end
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = 1'h1;
  assign hresp_o     = 1'h0;

  // ---- master clear pin synchroniser and assertion edge ----
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_r   <= 1'h1;
      pin_s2_r   <= 1'h1;
      pin_prev_r <= 1'h1;
    end else begin
      pin_s1_r   <= master_clear_input_n_i;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  assign pin_evt = pin_prev_r && !pin_s2_r;

  // ---- hardware set vector ----
  always_comb begin
    set_vec               = {DATA_W{1'h0}};
    set_vec[MISMATCH_BIT] = mismatch_evt_i;
    set_vec[EXT_BIT]      = pin_evt;
    set_vec[SW_BIT]       = sw_reset_evt_i;
    set_vec[WDT_BIT]      = wdt_timeout_evt_i;
    set_vec[SLEEP_BIT]    = sleep_wake_evt_i;
    set_vec[IDLE_BIT]     = idle_wake_evt_i;
    set_vec[BROWNOUT_BIT] = brownout_evt_i;
    set_vec[POR_BIT]      = poweron_evt_i;
  end

  // software write first, hardware set on top so a set is never lost
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = hwdata_i & CTL_IMPL_MASK;
    end
    ctl_nxt = (ctl_nxt | set_vec) & CTL_IMPL_MASK;
  end

  // nrst_i is the power-on / brown-out reset, so those flags come up set
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r <= CTL_RESET;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ---- regulator control ----
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_on_r <= 1'h1;
    end else begin
      reg_on_r <= !in_sleep_i || ctl_r[REG_STBY_BIT];
    end
  end

  assign regulator_on_o             = reg_on_r;
  assign regulator_standby_enable_o = ctl_r[REG_STBY_BIT];

  // ---- interrupt bank ----
  assign irq_bus.evt    = set_vec[FLAG_W-1:0];
  assign irq_bus.clr_we = wr_int_clear;
  assign irq_bus.en_we  = wr_int_enable;
  assign irq_bus.wdata  = hwdata_i[FLAG_W-1:0];
  assign irq_o          = irq_bus.irq;

  // ---- checks ----
  property p_mismatch_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      mismatch_evt_i |=> ctl_r[MISMATCH_BIT];
  endproperty
  a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch flag not set");

  property p_mismatch_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[MISMATCH_BIT] && !mismatch_evt_i && !wr_ctl) |=> !ctl_r[MISMATCH_BIT];
  endproperty
  a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("mismatch flag set without cause");

  property p_reg_sleep_off;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (in_sleep_i && !ctl_r[REG_STBY_BIT]) |=> !regulator_on_o;
  endproperty
  a_reg_sleep_off: assert property (p_reg_sleep_off) else $error("regulator on in sleep");

  property p_reg_sleep_on;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!in_sleep_i || ctl_r[REG_STBY_BIT]) |=> regulator_on_o;
  endproperty
  a_reg_sleep_on: assert property (p_reg_sleep_on) else $error("regulator off while needed");

  property p_pin_flag;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (pin_s1_r && !master_clear_input_n_i) ##1 !pin_s1_r ##1 !pin_s2_r |=> ctl_r[EXT_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin reset flag not set");

  property p_sw_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      sw_reset_evt_i |=> ctl_r[SW_BIT];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software reset flag not set");

  property p_sw_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[SW_BIT] && !sw_reset_evt_i && !wr_ctl) |=> !ctl_r[SW_BIT];
  endproperty
  a_sw_quiet: assert property (p_sw_quiet) else $error("software reset flag set without cause");

  property p_wdt_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wdt_timeout_evt_i && wr_ctl && !hwdata_i[WDT_BIT]) |=> ctl_r[WDT_BIT];
  endproperty
  a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag lost to a clear");

  property p_wdt_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[WDT_BIT] && !wdt_timeout_evt_i && !wr_ctl) |=> !ctl_r[WDT_BIT];
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog flag set without cause");

  property p_wake_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (sleep_wake_evt_i || idle_wake_evt_i) |=>
        ($past(sleep_wake_evt_i) -> ctl_r[SLEEP_BIT]) && ($past(idle_wake_evt_i) -> ctl_r[IDLE_BIT]);
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

  property p_sleep_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[SLEEP_BIT] && !sleep_wake_evt_i && !wr_ctl) |=> !ctl_r[SLEEP_BIT];
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep wake flag set without cause");

  property p_idle_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[IDLE_BIT] && !idle_wake_evt_i && !wr_ctl) |=> !ctl_r[IDLE_BIT];
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle wake flag set without cause");

  property p_brownout_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      brownout_evt_i |=> ctl_r[BROWNOUT_BIT] && irq_bus.status[BROWNOUT_BIT];
  endproperty
  a_brownout_set: assert property (p_brownout_set) else $error("brown-out flag not set");

  property p_por_set;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      poweron_evt_i |=> ctl_r[POR_BIT];
  endproperty
  a_por_set: assert property (p_por_set) else $error("power-on flag not set");

  property p_reserved_zero;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      ((acc_r == ACC_READ) && is_reg(addr_r, CTL_ADDR)) |-> ((hrdata_o & ~CTL_IMPL_MASK) == HRDATA_RESET);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  property p_sw_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_ctl && set_vec == {DATA_W{1'h0}}) |=> ctl_r == ($past(hwdata_i) & CTL_IMPL_MASK);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software write not stored");

  property p_por_write;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_ctl && !poweron_evt_i) |=> (ctl_r[POR_BIT] == $past(hwdata_i[POR_BIT]));
  endproperty
  a_por_write: assert property (p_por_write) else $error("power-on flag write not stored");

  property p_flag_holds;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (ctl_r[POR_BIT] && !wr_ctl) |=> ctl_r[POR_BIT];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("power-on flag dropped without clear");

  property p_brownout_holds;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (ctl_r[BROWNOUT_BIT] && !wr_ctl) |=> ctl_r[BROWNOUT_BIT];
  endproperty
  a_brownout_holds: assert property (p_brownout_holds) else $error("brown-out flag dropped without clear");

  property p_no_stray_change;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $changed(ctl_r[WDT_BIT]) |-> ($past(wdt_timeout_evt_i) || $past(wr_ctl));
  endproperty
  a_no_stray_change: assert property (p_no_stray_change) else $error("watchdog flag changed by other cause");

  property p_ext_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (!ctl_r[EXT_BIT] && !pin_evt && !wr_ctl) |=> !ctl_r[EXT_BIT];
  endproperty
  a_ext_quiet: assert property (p_ext_quiet) else $error("pin reset flag set without cause");

  property p_irq_quiet;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !(|(irq_bus.status & irq_bus.enable)) |=> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq raised with no enabled status");

  property p_bus_okay;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      hreadyout_o && !hresp_o;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");

endmodule : reset_cause_status_register

// File: hdl/rcause_pkg.sv
package rcause_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 10;

  // register byte addresses
  localparam logic [31:0] CTL_ADDR        = 32'h0000_0000;
  localparam logic [31:0] INT_STATUS_ADDR = 32'h0000_0004;
  localparam logic [31:0] INT_CLEAR_ADDR  = 32'h0000_0008;
  localparam logic [31:0] INT_ENABLE_ADDR = 32'h0000_000C;

  // field positions of reset_cause_control
  localparam int unsigned MISMATCH_BIT = 9;
  localparam int unsigned REG_STBY_BIT = 8;
  localparam int unsigned EXT_BIT      = 7;
  localparam int unsigned SW_BIT       = 6;
  localparam int unsigned WDT_BIT      = 4;
  localparam int unsigned SLEEP_BIT    = 3;
  localparam int unsigned IDLE_BIT     = 2;
  localparam int unsigned BROWNOUT_BIT = 1;
  localparam int unsigned POR_BIT      = 0;

  // implemented bits, hardware-set bits, values after reset
  localparam logic [DATA_W-1:0] CTL_IMPL_MASK  = 32'h0000_03DF;
  localparam logic [FLAG_W-1:0] EVT_MASK       = 10'h2DF;
  localparam logic [DATA_W-1:0] CTL_RESET      = 32'h0000_0003;
  localparam logic [FLAG_W-1:0] INT_RESET      = 10'h000;
  localparam logic [DATA_W-1:0] HRDATA_RESET   = 32'h0000_0000;

  // htrans encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } access_t;

endpackage : rcause_pkg

// File: hdl/irq_if.sv
`timescale 1ns/10ps
interface irq_if;
  import rcause_pkg::*;

  logic [FLAG_W-1:0] evt;
  logic              clr_we;
  logic              en_we;
  logic [FLAG_W-1:0] wdata;
  logic [FLAG_W-1:0] status;
  logic [FLAG_W-1:0] enable;
  logic              irq;

  modport ctrl (output evt, output clr_we, output en_we, output wdata,
                input status, input enable, input irq);
  modport bank (input evt, input clr_we, input en_we, input wdata,
                output status, output enable, output irq);

endinterface : irq_if

// File: hdl/irq_bank.sv
`timescale 1ns/10ps
module irq_bank (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  irq_if.bank       bus
);
  import rcause_pkg::*;

  logic [FLAG_W-1:0] status_r;
  logic [FLAG_W-1:0] enable_r;
  logic              irq_r;

  // sticky status, event wins over a clear in the same cycle
  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++) begin : g_stat
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          status_r[i] <= INT_RESET[i];
        end else if (bus.evt[i] && EVT_MASK[i]) begin
          status_r[i] <= 1'h1;
        end else if (bus.clr_we && bus.wdata[i]) begin
          status_r[i] <= 1'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable_r <= INT_RESET;
    end else if (bus.en_we) begin
      enable_r <= bus.wdata & EVT_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= |(status_r & enable_r);
    end
  end

  assign bus.status = status_r;
  assign bus.enable = enable_r;
  assign bus.irq    = irq_r;

  property p_irq_level;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      |(status_r & enable_r) |=> irq_r;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised for enabled status");

  property p_evt_beats_clear;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      (bus.evt[WDT_BIT] && bus.clr_we && bus.wdata[WDT_BIT]) |=> status_r[WDT_BIT];
  endproperty
  a_evt_beats_clear: assert property (p_evt_beats_clear) else $error("clear beat a same-cycle event");

endmodule : irq_bank

// File: dv/reset_cause_status_register_tb_top.sv
`timescale 1ns/10ps
module reset_cause_status_register_tb_top;
  import rcause_pkg::*;
  localparam logic [31:0] ctl_a = 32'h0000_0000;
  localparam logic [31:0] bad_a = 32'h0000_0010;
  logic        clk_sys_i;
  logic        nrst_i;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic        in_sleep;
  logic        clr_pin_n;
  logic        reg_on;
  logic        stby;
  logic        irq;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [6:0]  ev;
  int          err_count;
  int          n_checks;
  int          m_ctl;
  int          m_st;
  int          m_en;
  int          k;
  int          pos [7] = '{9, 6, 4, 3, 2, 1, 0};

  reset_cause_status_register dut_u (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .mismatch_evt_i(ev[0]), .sw_reset_evt_i(ev[1]),
    .wdt_timeout_evt_i(ev[2]), .sleep_wake_evt_i(ev[3]), .idle_wake_evt_i(ev[4]),
    .brownout_evt_i(ev[5]), .poweron_evt_i(ev[6]), .master_clear_input_n_i(clr_pin_n),
    .in_sleep_i(in_sleep), .regulator_on_o(reg_on), .regulator_standby_enable_o(stby), .irq_o(irq)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run;
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_i);
      if (hready === 1'b1) return;
    end
    err_count++;
    complete_run();
  endtask : wait_rdy

  // single transfer: address phase, then data phase with htrans idle
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == ctl_a) m_ctl = d & 32'h0000_03DF;
    if (a == INT_CLEAR_ADDR) m_st = m_st & ~int'(d & 32'h0000_03FF);
    if (a == INT_ENABLE_ADDR) m_en = d & 32'h0000_02DF;
  endtask : wr

  task automatic rd_chk(input logic [31:0] a);
    int e;
    e = 0;
    if (a == ctl_a) e = m_ctl;
    if (a == INT_STATUS_ADDR) e = m_st;
    if (a == INT_ENABLE_ADDR) e = m_en;
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, 32'(e));
    chk(32'(hresp), 32'h0000_0000);
  endtask : rd_chk

  // watchdog pulse in the same cycle as the write's data phase
  task automatic race(input logic [31:0] a, input logic [31:0] d);
    fork
      wr(a, d);
      begin
        repeat (2) @(posedge clk_sys_i);
        ev <= 7'h04;
        @(posedge clk_sys_i);
        ev <= 7'h00;
      end
    join
    m_ctl = m_ctl | 32'h0000_0010;
    m_st  = m_st | 32'h0000_0010;
  endtask : race

  // one-cycle pulses on the selected cause inputs
  task automatic fire(input logic [6:0] m);
    @(posedge clk_sys_i);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 7'h00;
    for (int j = 0; j < 7; j++) begin
      if (m[j]) begin
        m_ctl = m_ctl | (1 << pos[j]);
        m_st  = m_st | (1 << pos[j]);
      end
    end
  endtask : fire

  task automatic chk_irq;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(32'(irq), 32'((m_st & m_en) != 0));
  endtask : chk_irq

  task automatic settle_chk(input logic exp_on, input logic exp_stby);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(32'({reg_on, stby}), 32'({exp_on, exp_stby}));
  endtask : settle_chk

  initial begin
    nrst_i = 1'b0; hsel = 1'b0; haddr = '0; htrans = HTRANS_IDLE; hwrite = 1'b0; hwdata = '0;
    ev = '0; in_sleep = 1'b0; clr_pin_n = 1'b1; err_count = 0; n_checks = 0;
    m_ctl = 3; m_st = 0; m_en = 0;
    void'($urandom(12005));
    repeat (11) @(posedge clk_sys_i);
    #1;
    chk(32'({reg_on, stby, irq}), 32'h0000_0004);
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd_chk(ctl_a);
    rd_chk(INT_STATUS_ADDR);
    rd_chk(INT_ENABLE_ADDR);
    wr(ctl_a, 32'hFFFF_FFFF);
    rd_chk(ctl_a);
    wr(ctl_a, 32'h0000_0000);
    rd_chk(ctl_a);
    for (k = 0; k < 4; k++) begin
      wr(ctl_a, $urandom);
      rd_chk(ctl_a);
    end
    wr(ctl_a, 32'h0000_0000);
    wr(bad_a, 32'hFFFF_FFFF);
    rd_chk(bad_a);
    rd_chk(INT_CLEAR_ADDR);
    rd_chk(ctl_a);
    wr(INT_ENABLE_ADDR, 32'hFFFF_FFFF);
    rd_chk(INT_ENABLE_ADDR);
    for (k = 0; k < 7; k++) begin
      fire(7'(1 << k));
      chk_irq();
      rd_chk(ctl_a);
      rd_chk(INT_STATUS_ADDR);
    end
    @(posedge clk_sys_i);
    clr_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    clr_pin_n <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m_ctl = m_ctl | 32'h0000_0080;
    m_st  = m_st | 32'h0000_0080;
    rd_chk(ctl_a);
    chk_irq();
    repeat (50) @(posedge clk_sys_i);
    rd_chk(ctl_a);
    wr(INT_CLEAR_ADDR, 32'hFFFF_FFFF);
    chk_irq();
    rd_chk(INT_STATUS_ADDR);
    rd_chk(ctl_a);
    wr(INT_ENABLE_ADDR, 32'h0000_0010);
    fire(7'h04);
    chk_irq();
    fire(7'h01);
    wr(INT_CLEAR_ADDR, 32'h0000_0010);
    chk_irq();
    rd_chk(INT_STATUS_ADDR);
    race(INT_CLEAR_ADDR, 32'h0000_0010);
    rd_chk(INT_STATUS_ADDR);
    race(ctl_a, 32'h0000_0000);
    rd_chk(ctl_a);
    wr(ctl_a, 32'h0000_0000);
    wr(INT_CLEAR_ADDR, 32'hFFFF_FFFF);
    wr(INT_ENABLE_ADDR, $urandom);
    for (k = 0; k < 20; k++) begin
      fire(7'($urandom));
      chk_irq();
      rd_chk(ctl_a);
      rd_chk(INT_STATUS_ADDR);
      if (k % 5 == 4) wr(ctl_a, $urandom);
    end
    wr(ctl_a, 32'h0000_0000);
    @(posedge clk_sys_i);
    in_sleep <= 1'b1;
    settle_chk(1'b0, 1'b0);
    wr(ctl_a, 32'h0000_0100);
    settle_chk(1'b1, 1'b1);
    @(posedge clk_sys_i);
    in_sleep <= 1'b0;
    wr(ctl_a, 32'h0000_0000);
    settle_chk(1'b1, 1'b0);
    fire(7'h02);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    m_ctl = 3;
    m_st  = 0;
    m_en  = 0;
    rd_chk(ctl_a);
    rd_chk(INT_ENABLE_ADDR);
    chk_irq();
    complete_run();
  end

endmodule : reset_cause_status_register_tb_top
